// ### rtl/fecf_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - erase: two unlocks then setup at fixed address
// - sixth cycle confirm code at block address
// - more confirms add blocks, restart timeout
// - fail flag set: host issues reset command
// - program: two unlocks then program code
// - suspend code any address, only during erase
// - toggle stops within limit, poll outside blocks
// - resume code any address, no unlocks
module fecf_ctrl #(
  parameter logic [18:0] UNLOCK1_ADDR = 19'h00000, // first unlock address
  parameter logic [7:0] UNLOCK1_DATA = 8'h00, // first unlock byte
  parameter logic [18:0] UNLOCK2_ADDR = 19'h00001, // second unlock address
  parameter logic [7:0] UNLOCK2_DATA = 8'h01, // second unlock byte
  parameter logic [7:0] RESET_CODE = 8'hFF // reset command byte
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fecf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [fecf_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output fecf_pkg::fecf_pins_t flash_pins,
  input wire logic [7:0] flash_dq_in
);
  import fecf_pkg::*;

  // ----------------
  // data input synchroniser
  // ----------------
  logic [7:0] dq_meta_q; // first stage, read only by dq_sync_q
  logic [7:0] dq_sync_q;

  // the flash answers without our clock, so two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_meta_q <= '0;
      dq_sync_q <= '0;
    end else if (clk_en) begin
      dq_meta_q <= flash_dq_in;
      dq_sync_q <= dq_meta_q;
    end
  end

  // ----------------
  // AXI4-Lite write channel
  // ----------------
  logic awready_q, wready_q, bvalid_q; // channel handshakes
  logic aw_hold_q, w_hold_q; // address / data taken, waiting for partner
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic [18:0] addr_q; // flash address register
  logic [7:0] wdata8_q; // program byte register
  logic [31:0] wmask; // byte-enable mask

  wire aw_hs = s_axi_awvalid & awready_q;
  wire w_hs = s_axi_wvalid & wready_q;
  wire wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  wire sel_ctrl = (awaddr_q == REG_CTRL);
  wire sel_addr = (awaddr_q == REG_ADDR);
  wire sel_wdat = (awaddr_q == REG_WDATA);
  wire wr_known = sel_ctrl | sel_addr | sel_wdat | (awaddr_q == REG_STATUS);

  // byte lanes select which bits a write changes
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wmask[8*g +: 8] = {8{wstrb_q[g]}};
  end
  wire [31:0] addr_merged = ({13'h0, addr_q} & ~wmask) | (wdata_q & wmask);
  wire [31:0] wdat_merged = ({24'h0, wdata8_q} & ~wmask) | (wdata_q & wmask);

  // address and data are taken in either order, the answer follows both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      addr_q <= ADDR_RST;
      wdata8_q <= WDATA_RST;
    end else if (clk_en) begin
      if (aw_hs) begin
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
        if (sel_addr) addr_q <= addr_merged[18:0];
        if (sel_wdat) wdata8_q <= wdat_merged[7:0];
      end
      if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ----------------
  // operation sequencer
  // ----------------
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000,
    SQ_ISSUE = 3'b001,
    SQ_WAITC = 3'b011,
    SQ_EVAL = 3'b010,
    SQ_FINISH = 3'b110
  } fecf_sq_t;

  fecf_sq_t sq_q; // sequencer state
  fecf_op_t op_q; // operation under way
  logic [2:0] step_q; // bus cycle index within the operation
  logic cyc_start_q; // one-cycle start to the pin sequencer
  logic have_prev_q; // a first poll read is stored
  logic [7:0] prev_q; // previous poll read
  logic [7:0] last_rd_q; // last byte read back
  logic fail_seen_q; // fail flag seen once while toggling
  logic fail_q, tmo_q, auto_rst_q;
  logic [CNT_W-1:0] sus_cnt_q; // suspend settle timer
  logic cyc_done;
  logic [7:0] cyc_rdata;

  // a new order is taken only when idle; a busy write is ignored
  wire start_op = wr_fire & sel_ctrl & wstrb_q[0] & (sq_q == SQ_IDLE);
  wire fecf_op_t new_op = fecf_op_t'(wdata_q[CTRL_OP_LSB +: 3]);

  // write cycles per operation; the rest of an operation is reads
  wire is_prog = (op_q == OP_BYTE_WRITE_CMD);
  wire is_erase = (op_q == OP_BLOCK_WIPE_CMD);
  wire [2:0] nsteps = is_prog ? 3'd4 : is_erase ? 3'd6 :
                      (op_q == OP_READ || op_q == OP_POLL) ? 3'd0 : 3'd1;
  wire polls = is_prog | (op_q == OP_SUSPEND_CMD) | (op_q == OP_POLL);
  wire in_reads = (step_q >= nsteps);

  // command byte and address of the current write step
  wire unlk1 = (is_prog | is_erase) & (step_q == 3'd0 || (is_erase && step_q == 3'd3));
  wire unlk2 = (is_prog | is_erase) & (step_q == 3'd1 || (is_erase && step_q == 3'd4));
  wire setup = (is_prog | is_erase) & (step_q == 3'd2);
  wire [7:0] one_code = (op_q == OP_ADD_BLOCK) ? CMD_ERASE_CONFIRM :
                        (op_q == OP_SUSPEND_CMD) ? CMD_SUSPEND :
                        (op_q == OP_RESUME_CMD) ? CMD_RESUME : RESET_CODE;
  wire [7:0] last_code = is_prog ? wdata8_q :
                         is_erase ? CMD_ERASE_CONFIRM : one_code;
  wire [7:0] step_data = unlk1 ? UNLOCK1_DATA : unlk2 ? UNLOCK2_DATA :
                         setup ? (is_prog ? CMD_PROGRAM : CMD_ERASE_SETUP) :
                         last_code;
  // target address also serves suspend polling outside the erased blocks
  wire [18:0] step_addr = unlk1 ? UNLOCK1_ADDR : unlk2 ? UNLOCK2_ADDR :
                          setup ? SETUP_ADDR : addr_q;

  // poll evaluation on the byte just read
  wire toggling = have_prev_q & (prev_q[FLIP_STATUS_BIT] ^ cyc_rdata[FLIP_STATUS_BIT]);
  wire settled = have_prev_q & ~toggling;
  wire flagged = cyc_rdata[FAIL_FLAG];
  wire sus_over = (op_q == OP_SUSPEND_CMD) & (sus_cnt_q >= CNT_W'(SUSP_MAX_CYC));
  wire went_bad = (settled & flagged) | (toggling & flagged & fail_seen_q);

  // control flow of one operation: writes, then reads until settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sq_q <= SQ_IDLE;
      op_q <= OP_READ;
      step_q <= '0;
      cyc_start_q <= 1'b0;
      have_prev_q <= 1'b0;
      prev_q <= '0;
      last_rd_q <= '0;
      fail_seen_q <= 1'b0;
      fail_q <= 1'b0;
      tmo_q <= 1'b0;
      auto_rst_q <= 1'b0;
      sus_cnt_q <= '0;
    end else if (clk_en) begin
      cyc_start_q <= 1'b0;
      if (sq_q != SQ_IDLE && sus_cnt_q != '1) sus_cnt_q <= sus_cnt_q + 1'b1;
      case (sq_q)
        SQ_IDLE: begin
          if (start_op) begin
            op_q <= new_op;
            step_q <= '0;
            have_prev_q <= 1'b0;
            fail_seen_q <= 1'b0;
            fail_q <= 1'b0;
            tmo_q <= 1'b0;
            sus_cnt_q <= '0;
            sq_q <= SQ_ISSUE;
          end
        end
        SQ_ISSUE: begin
          cyc_start_q <= 1'b1;
          sq_q <= SQ_WAITC;
        end
        SQ_WAITC: begin
          if (cyc_done) sq_q <= SQ_EVAL;
        end
        SQ_EVAL: begin
          if (!in_reads) begin
            // another write step, a poll phase, or finished
            step_q <= step_q + 1'b1;
            sq_q <= (step_q + 1'b1 == nsteps && !polls) ? SQ_FINISH : SQ_ISSUE;
          end else begin
            // status byte, including the window flag after erase cycles
            last_rd_q <= cyc_rdata;
            prev_q <= cyc_rdata;
            have_prev_q <= 1'b1;
            if (op_q == OP_READ || settled) begin
              fail_q <= went_bad;
              auto_rst_q <= went_bad;
              sq_q <= SQ_FINISH;
            end else if (went_bad || sus_over) begin
              fail_q <= went_bad;
              tmo_q <= sus_over;
              auto_rst_q <= went_bad;
              sq_q <= SQ_FINISH;
            end else begin
              if (toggling & flagged) begin
                // fail flag while busy: confirm with one more pair
                fail_seen_q <= 1'b1;
                have_prev_q <= 1'b0;
              end
              sq_q <= SQ_ISSUE;
            end
          end
        end
        SQ_FINISH: begin
          if (auto_rst_q) begin
            // clear the device's write controller after a failure
            auto_rst_q <= 1'b0;
            op_q <= OP_RESET;
            step_q <= '0;
            sq_q <= SQ_ISSUE;
          end else begin
            sq_q <= SQ_IDLE;
          end
        end
        default: sq_q <= SQ_IDLE;
      endcase
    end
  end

  // ----------------
  // pin sequencer
  // ----------------
  fecf_cycle u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .start(cyc_start_q),
    .wr(~in_reads),
    .addr(step_addr),
    .data(step_data),
    .dq_sync(dq_sync_q),
    .pins(flash_pins),
    .done(cyc_done),
    .rdata(cyc_rdata)
  );

  // ----------------
  // AXI4-Lite read channel
  // ----------------
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire ar_hs = s_axi_arvalid & arready_q;
  wire [31:0] status_word = {16'h0, last_rd_q, 5'h0, tmo_q, fail_q, (sq_q != SQ_IDLE)};
  wire rd_ctrl = (s_axi_araddr == REG_CTRL);
  wire rd_addr = (s_axi_araddr == REG_ADDR);
  wire rd_wdat = (s_axi_araddr == REG_WDATA);
  wire rd_stat = (s_axi_araddr == REG_STATUS);
  wire [31:0] rd_word = rd_ctrl ? {29'h0, op_q} : rd_addr ? {13'h0, addr_q} :
                        rd_wdat ? {24'h0, wdata8_q} : rd_stat ? status_word : 32'h0;

  // answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (clk_en) begin
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= (rd_ctrl | rd_addr | rd_wdat | rd_stat) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q & s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule : fecf_ctrl

// ### shared/fecf_pkg.sv
package fecf_pkg;
  // ----------------
  // timing (clock and pin)
  // ----------------
  localparam int CLK_NS = 100; // aclk period
  localparam int WP_NS = 65; // least write strobe low time
  localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS; // rounded up
  localparam int RD_ACC_NS = 100; // read access time
  localparam int SYNC_STAGES = 2; // data input synchroniser depth
  localparam int RD_WAIT_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int SUSP_MAX_NS = 15000; // longest toggle stop after suspend
  localparam int SUSP_MAX_CYC = SUSP_MAX_NS / CLK_NS; // rounded down
  localparam int CNT_W = 8; // width of the small timing counters

  // ----------------
  // register map (byte offsets on the AXI4-Lite slave)
  // ----------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00; // op code, write starts it
  localparam logic [7:0] REG_ADDR = 8'h04; // flash byte address
  localparam logic [7:0] REG_WDATA = 8'h08; // byte to program
  localparam logic [7:0] REG_STATUS = 8'h0C; // read only
  localparam logic [18:0] ADDR_RST = 19'h00000;
  localparam logic [7:0] WDATA_RST = 8'h00;
  localparam int CTRL_OP_LSB = 0;
  localparam int ST_BUSY = 0; // status: operation under way
  localparam int ST_FAIL = 1; // status: operation failed
  localparam int ST_TMO = 2; // status: suspend did not settle in time
  localparam int ST_RD_LSB = 8; // status: last byte read back
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------
  // flash command codes and status bit positions
  // ----------------
  localparam logic [18:0] SETUP_ADDR = 19'h05555; // fixed command address
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam int DONE_POLL_BIT = 7;
  localparam int FLIP_STATUS_BIT = 6;
  localparam int FAIL_FLAG = 5;
  localparam int TIMER_WINDOW_FLAG = 3;

  // operations software can order
  typedef enum logic [2:0] {
    OP_READ = 3'h0, // one read, array or status
    OP_BYTE_WRITE_CMD = 3'h1, // byte program, then poll
    OP_BLOCK_WIPE_CMD = 3'h2, // full six-cycle block erase
    OP_ADD_BLOCK = 3'h3, // extra confirm inside the window
    OP_SUSPEND_CMD = 3'h4, // suspend, then poll until settled
    OP_RESUME_CMD = 3'h5,
    OP_RESET = 3'h6,
    OP_POLL = 3'h7 // poll until the toggle bit settles
  } fecf_op_t;

  // flash pin bundle driven by the host
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [18:0] addr;
    logic [7:0] dq_out;
    logic dq_oe_n; // low while the host drives dq
  } fecf_pins_t;
endpackage : fecf_pkg

// ### rtl/fecf_cycle.sv
`timescale 1ns/1ps
module fecf_cycle (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic wr,
  input wire logic [18:0] addr,
  input wire logic [7:0] data,
  input wire logic [7:0] dq_sync,
  output fecf_pkg::fecf_pins_t pins,
  output logic done,
  output logic [7:0] rdata
);
  import fecf_pkg::*;

  // ----------------
  // one bus cycle on the flash pins, write or read
  // ----------------
  typedef enum logic [2:0] {
    CY_IDLE = 3'b000,
    CY_SETUP = 3'b001,
    CY_STROBE = 3'b011,
    CY_HOLD = 3'b010,
    CY_END = 3'b110
  } fecf_cy_t;

  fecf_cy_t st_q; // cycle state
  fecf_pins_t pins_q; // registered pin drive
  logic [CNT_W-1:0] cnt_q; // strobe and access wait counter
  logic wr_q; // cycle kind
  logic done_q;
  logic [7:0] rdata_q;

  wire cnt_end = (cnt_q == '0);
  localparam logic [CNT_W-1:0] WP_LOAD = CNT_W'(WP_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_WAIT_CYC - 1);

  // state sequence; strobes idle high so the first edge after reset is a clean command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= CY_IDLE;
      pins_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: '0,
                  dq_oe_n: 1'b1};
      cnt_q <= '0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= '0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      case (st_q)
        CY_IDLE: begin
          if (start) begin
            // address and data set up before any strobe falls
            wr_q <= wr;
            pins_q.addr <= addr;
            pins_q.dq_out <= data;
            pins_q.dq_oe_n <= ~wr;
            pins_q.ce_n <= 1'b0;
            st_q <= CY_SETUP;
          end
        end
        CY_SETUP: begin
          // write: address latched on this falling edge; read: output enable on
          pins_q.we_n <= ~wr_q;
          pins_q.oe_n <= wr_q;
          cnt_q <= wr_q ? WP_LOAD : RD_LOAD;
          st_q <= CY_STROBE;
        end
        CY_STROBE: begin
          if (cnt_end) begin
            // rising write edge latches the data byte
            pins_q.we_n <= 1'b1;
            st_q <= CY_HOLD;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        CY_HOLD: begin
          // data held two cycles past the rising edge, read sampled here
          rdata_q <= dq_sync;
          pins_q.oe_n <= 1'b1;
          st_q <= CY_END;
        end
        CY_END: begin
          pins_q.ce_n <= 1'b1;
          pins_q.dq_oe_n <= 1'b1;
          done_q <= 1'b1;
          st_q <= CY_IDLE;
        end
        default: st_q <= CY_IDLE;
      endcase
    end
  end

  assign pins = pins_q;
  assign done = done_q;
  assign rdata = rdata_q;
endmodule : fecf_cycle

// ### tb/fecf_flash_model.sv
`timescale 1ns/1ps
// busy times count status reads, not real time
module fecf_flash_model (
  input wire fecf_pkg::fecf_pins_t pins,
  input wire logic fail_inj,
  output logic [7:0] dq_in,
  output int resets
);
  import fecf_pkg::*;
  typedef enum {RD, PROG, WIN, ERS, SUSP} fecf_fst_t;
  fecf_fst_t st = RD; // array read from power up
  logic [7:0] mem [0:7][0:15]; // 16 bytes per block are enough here
  logic [7:0] blk = 8'h00, q = 8'h00, d;
  logic [18:0] a;
  logic tg = 1'b0, fail = 1'b0, prg = 1'b0, setup = 1'b0;
  int cyc = 0, cnt = 0;
  initial resets = 0;
  initial foreach (mem[i, j]) mem[i][j] = 8'hFF;
  // address on the falling strobe, data on the rising one
  always @(negedge pins.we_n) if (!pins.ce_n) a = pins.addr;
  always @(posedge pins.we_n) if (!pins.ce_n) begin
    d = pins.dq_out;
    if (d == 8'hFF && st != PROG) begin
      if (st == SUSP) foreach (mem[i, j]) if (blk[i]) mem[i][j] = 8'hA5;
      st = RD;
      fail = 1'b0;
      cyc = 0;
      setup = 1'b0;
      resets++;
    end else case (st)
      RD: if (prg) begin
          mem[a[18:16]][a[3:0]] = mem[a[18:16]][a[3:0]] & d;
          prg = 1'b0;
          st = PROG;
          cnt = 3;
        end else if (cyc == 0 && a == 19'h00000 && d == 8'h00) cyc = 1;
        else if (cyc == 1 && a == 19'h00001 && d == 8'h01) cyc = 2;
        else if (cyc == 2 && a == SETUP_ADDR && d == CMD_PROGRAM && !setup) begin
          prg = 1'b1;
          cyc = 0;
        end else if (cyc == 2 && a == SETUP_ADDR && d == CMD_ERASE_SETUP) begin
          setup = 1'b1;
          cyc = 0;
        end else if (cyc == 2 && setup && d == CMD_ERASE_CONFIRM) begin
          setup = 1'b0;
          cyc = 0;
          blk = 8'h00;
          blk[a[18:16]] = 1'b1;
          st = WIN;
          cnt = 4;
        end else begin
          cyc = 0;
          setup = 1'b0;
        end
      WIN: if (d == CMD_ERASE_CONFIRM) begin
          blk[a[18:16]] = 1'b1;
          cnt = 4;
        end else st = (d == CMD_SUSPEND) ? SUSP : RD;
      ERS: if (d == CMD_SUSPEND) st = SUSP;
      SUSP: if (d == CMD_RESUME) st = ERS;
      default: ;
    endcase
  end
  // a read gives array data, or gives the status byte and then advances the timers
  always @(negedge pins.oe_n) if (!pins.ce_n) begin
    if (st == RD || st == SUSP) begin
      q = (st == SUSP && blk[pins.addr[18:16]]) ? 8'hA5 : mem[pins.addr[18:16]][pins.addr[3:0]];
    end else begin
      tg = ~tg;
      q = {1'b0, tg, fail, 1'b0, st == ERS, 3'b000};
      if (cnt > 0) cnt--;
      if (cnt == 0 && !fail) case (st)
        PROG: st = RD;
        WIN: begin
          st = ERS;
          cnt = 6;
        end
        default: if (fail_inj) fail = 1'b1;
          else begin
            foreach (mem[i, j]) if (blk[i]) mem[i][j] = 8'hFF;
            st = RD;
          end
      endcase
    end
  end
  // released bus shows the inverse, not a stale value
  assign dq_in = (!pins.ce_n && !pins.oe_n) ? q : ~q;
endmodule : fecf_flash_model

// ### tb/fecf_ctrl_sva.sv
`timescale 1ns/1ps
module fecf_ctrl_sva
  import fecf_pkg::*;
#(
  parameter logic [18:0] UNLOCK1_ADDR = 19'h00000,
  parameter logic [7:0] UNLOCK1_DATA = 8'h00,
  parameter logic [18:0] UNLOCK2_ADDR = 19'h00001,
  parameter logic [7:0] UNLOCK2_DATA = 8'h01
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire fecf_pins_t flash_pins
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [26:0] w0_q, w1_q, w2_q; // last three strobed writes
  always_ff @(posedge aclk) if ($fell(flash_pins.we_n)) begin
    w0_q <= {flash_pins.addr, flash_pins.dq_out};
    w1_q <= w0_q;
    w2_q <= w1_q;
  end
  wire unl_ok = w1_q == {UNLOCK2_ADDR, UNLOCK2_DATA} && w2_q == {UNLOCK1_ADDR, UNLOCK1_DATA};
  a_strobe_framed: assert property (!flash_pins.we_n |-> !flash_pins.ce_n && !flash_pins.dq_oe_n)
    else $error("write strobe outside a driven cycle");
  a_strobe_width: assert property ($fell(flash_pins.we_n) |=> flash_pins.we_n)
    else $error("write strobe not one cycle");
  a_latch_hold: assert property ($rose(flash_pins.we_n) |-> $stable(flash_pins.addr) &&
    $stable(flash_pins.dq_out) && !flash_pins.ce_n) else $error("bus moved at strobe end");
  a_no_contention: assert property (!flash_pins.oe_n |-> flash_pins.dq_oe_n && flash_pins.we_n)
    else $error("read while driving");
  a_setup_unlocked: assert property ($rose(flash_pins.we_n) && w0_q == {SETUP_ADDR, CMD_ERASE_SETUP}
    |-> unl_ok) else $error("erase setup without unlocks");
  a_prog_unlocked: assert property ($rose(flash_pins.we_n) && w0_q == {SETUP_ADDR, CMD_PROGRAM}
    |-> unl_ok) else $error("program code without unlocks");
  a_reset_idle: assert property ($rose(aresetn) |-> flash_pins.ce_n && flash_pins.we_n &&
    flash_pins.oe_n && flash_pins.dq_oe_n) else $error("pins not idle after reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
endmodule : fecf_ctrl_sva
bind fecf_ctrl fecf_ctrl_sva #(.UNLOCK1_ADDR(UNLOCK1_ADDR), .UNLOCK1_DATA(UNLOCK1_DATA),
  .UNLOCK2_ADDR(UNLOCK2_ADDR), .UNLOCK2_DATA(UNLOCK2_DATA)) u_sva (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .flash_pins);

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import fecf_pkg::*;
  typedef struct packed {
    fecf_op_t op;
    logic [18:0] addr;
    logic [7:0] wd, mask, exp; // mask picks the read byte bits that matter
  } fecf_row_t;
  localparam fecf_row_t ROWS [10] = '{
    '{OP_BYTE_WRITE_CMD, 19'h00010, 8'h5A, 8'h00, 8'h00},
    '{OP_READ, 19'h00010, 8'h00, 8'hFF, 8'h5A},
    '{OP_BYTE_WRITE_CMD, 19'h00010, 8'hF0, 8'h00, 8'h00},
    '{OP_READ, 19'h00010, 8'h00, 8'hFF, 8'h50},
    '{OP_BYTE_WRITE_CMD, 19'h10010, 8'h13, 8'h00, 8'h00},
    '{OP_BLOCK_WIPE_CMD, 19'h10010, 8'h00, 8'h00, 8'h00},
    '{OP_READ, 19'h00010, 8'h00, 8'hA8, 8'h00},
    '{OP_POLL, 19'h00010, 8'h00, 8'h00, 8'h00},
    '{OP_READ, 19'h10010, 8'h00, 8'hFF, 8'hFF},
    '{OP_READ, 19'h00010, 8'h00, 8'hFF, 8'h50}};
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, fail_inj = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, dq_in;
  logic [31:0] wdata = 32'h00000000, rdata, st;
  logic [1:0] bresp, rresp, resp;
  fecf_pins_t pins;
  int failures = 0, num_checks = 0, resets, n;
  fecf_ctrl dut (.aclk, .aresetn, .clk_en, .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .flash_pins(pins), .flash_dq_in(dq_in));
  fecf_flash_model flash (.pins, .fail_inj, .dq_in, .resets);
  initial forever #50 aclk = ~aclk;
  task automatic fail_msg(input string msg);
    $display("ERROR %0t %s", $time, msg);
    failures++;
  endtask : fail_msg
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) fail_msg(msg);
  endtask : chk
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // both channels offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 100);
    resp = bresp;
    bready <= 1'b0;
    if (k >= 100) begin
      fail_msg("write hung");
      complete_run();
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 100);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (k >= 100) begin
      fail_msg("read hung");
      complete_run();
    end
  endtask : axi_rd
  // order one operation and wait until busy clears
  task automatic run_op(input fecf_op_t op, input logic [18:0] a, input logic [7:0] d = 8'h00);
    int k;
    axi_wr(REG_ADDR, 32'(a));
    axi_wr(REG_WDATA, 32'(d));
    axi_wr(REG_CTRL, 32'(op));
    k = 0;
    do begin
      axi_rd(REG_STATUS, st);
      k++;
    end while (st[ST_BUSY] !== 1'b0 && k < 500);
    if (k >= 500) begin
      fail_msg("operation hung");
      complete_run();
    end
  endtask : run_op
  initial begin
    repeat (90000) @(posedge aclk);
    fail_msg("run timeout");
    complete_run();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ROWS[i]) begin
      run_op(ROWS[i].op, ROWS[i].addr, ROWS[i].wd);
      chk(st[ST_FAIL] === 1'b0 && (st[15:8] & ROWS[i].mask) === ROWS[i].exp, "row");
      $display("row %0d done", i);
    end
    // reset inside the window leaves data; then two blocks in one window
    run_op(OP_BYTE_WRITE_CMD, 19'h20005, 8'h12);
    run_op(OP_BYTE_WRITE_CMD, 19'h30005, 8'h14);
    run_op(OP_BLOCK_WIPE_CMD, 19'h20005);
    run_op(OP_RESET, 19'h20005);
    run_op(OP_READ, 19'h20005);
    chk(st[15:8] === 8'h12, "aborted erase changed data");
    run_op(OP_BLOCK_WIPE_CMD, 19'h20005);
    run_op(OP_ADD_BLOCK, 19'h30005);
    run_op(OP_POLL, 19'h00010);
    run_op(OP_READ, 19'h30005);
    chk(st[15:8] === 8'hFF, "added block not erased");
    $display("window test done");
    run_op(OP_BYTE_WRITE_CMD, 19'h40003, 8'h47);
    run_op(OP_BLOCK_WIPE_CMD, 19'h50003);
    run_op(OP_SUSPEND_CMD, 19'h40003);
    chk({st[ST_TMO], st[ST_FAIL]} === 2'b00, "suspend not settled");
    run_op(OP_READ, 19'h40003);
    chk(st[15:8] === 8'h47, "read beside suspended erase");
    run_op(OP_RESUME_CMD, 19'h40003);
    run_op(OP_POLL, 19'h40003);
    run_op(OP_READ, 19'h50003);
    chk(st[15:8] === 8'hFF, "resumed erase incomplete");
    $display("suspend test done");
    n = resets;
    fail_inj <= 1'b1;
    run_op(OP_BLOCK_WIPE_CMD, 19'h60000);
    run_op(OP_POLL, 19'h40003);
    chk(st[ST_FAIL] === 1'b1 && resets == n + 1, "erase failure not handled");
    fail_inj <= 1'b0;
    $display("failure test done");
    axi_rd(8'h10, st);
    chk(resp === RESP_SLVERR && st === 32'h00000000, "unmapped read");
    axi_wr(REG_STATUS, 32'hFFFFFFFF);
    chk(resp === RESP_OKAY, "status write");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(REG_ADDR, st);
    chk(st === 32'(ADDR_RST), "address reset value");
    axi_rd(REG_WDATA, st);
    chk(st === 32'(WDATA_RST), "data reset value");
    $display("register test done");
    complete_run();
  end
endmodule : tb
